// file: core/arc_pkg.sv
// package: constants, types and carriers of the converter control block
// Notes on behaviour
// - single-ended result is unsigned 10-bit code
// - overrange single-ended input saturates at top code
// - differential result is 10-bit two's complement
// - result sign bit set means negative difference
// - result bytes readable once done flag set
// - four reference sources are selectable
// - halted cpu in quiet sleep starts conversion
// - completion wakes cpu and requests interrupt
// - earlier wake still gets completion request later
// - cpu stays awake until next sleep
// - converter stays powered in other sleep modes
// - reference field 00 pin, 01 supply, 10/11 internal
// - completion writes result, sets flag, clears start
// - left adjust takes effect immediately
package arc_pkg;

    // ****************************************************
    // register map, byte addresses
    // ****************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_RES_LO = 8'h08;
    localparam logic [7:0] ADDR_RES_HI = 8'h0c;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_IE_BIT = 2;
    localparam int CTRL_DONE_BIT = 3;
    localparam int CTRL_BUSY_BIT = 4;

    // selection register fields
    localparam int SEL_REF_LSB = 0;
    localparam int SEL_LADJ_BIT = 2;
    localparam int SEL_DIFF_BIT = 3;

    // ****************************************************
    // result layout
    // ****************************************************
    localparam int RES_W = 10;
    localparam int RES_MSB = 9;
    localparam int LADJ_SHIFT = 6;
    localparam logic [RES_W-1:0] RES_TOP = 10'h3ff;
    localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
    localparam logic [RES_W-1:0] RES_ONE = 10'h001;
    localparam logic [3:0] RES_TOP_IDX = 4'h9;

    // reference select codes
    typedef enum logic [1:0] {
        ARC_REF_PIN = 2'h0,
        ARC_REF_SUPPLY = 2'h1,
        ARC_REF_1V1 = 2'h2,
        ARC_REF_2V56 = 2'h3
    } arc_ref_t;

    // sleep mode reported by the sleep controller
    typedef enum logic [1:0] {
        ARC_SLP_ACTIVE = 2'h0,
        ARC_SLP_IDLE = 2'h1,
        ARC_SLP_NOISE = 2'h2,
        ARC_SLP_OTHER = 2'h3
    } arc_sleep_t;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BIT_SETTLE_NS = 16;
    localparam int INIT_SETTLE_NS = 200;
    localparam int BIT_SETTLE_CYC = (BIT_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INIT_SETTLE_CYC = (INIT_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_W = 8;
    localparam logic [SETTLE_W-1:0] BIT_SETTLE = SETTLE_W'(BIT_SETTLE_CYC);
    localparam logic [SETTLE_W-1:0] INIT_SETTLE = SETTLE_W'(INIT_SETTLE_CYC);
    localparam logic [SETTLE_W-1:0] SETTLE_ONE = 8'h01;

    // ****************************************************
    // carriers
    // ****************************************************
    typedef enum {
        ARC_CV_IDLE,
        ARC_CV_SETTLE,
        ARC_CV_DONE
    } arc_conv_st_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } arc_wb_req_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } arc_res_pair_t;

endpackage : arc_pkg

// file: core/arc_pin_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module arc_pin_sync (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } arc_sync_st_t;

    arc_sync_st_t st_ff;
    arc_sync_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // change counts only once stages two and three agree
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.level = st_ff.s3;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign level_o = st_ff.level;

endmodule : arc_pin_sync

// file: core/arc_result_format.sv
// registered justification of the 10-bit result into the byte pair
`timescale 1ns/1ps
module arc_result_format (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [arc_pkg::RES_W-1:0] result_i,
    input wire logic left_adjust_result_i,
    output arc_pkg::arc_res_pair_t pair_o
);

    typedef struct packed {
        arc_pkg::arc_res_pair_t pair;
    } arc_fmt_st_t;

    arc_fmt_st_t st_ff;
    arc_fmt_st_t nxt_st;
    logic [15:0] word;

    always_comb
    begin
        nxt_st = st_ff;
        if (left_adjust_result_i)
        begin
            word = {result_i, 6'h00};
        end
        else
        begin
            word = {6'h00, result_i};
        end
        // follows the adjust bit every cycle, also mid-conversion
        nxt_st.pair.lo = word[7:0];
        nxt_st.pair.hi = word[15:8];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pair_o = st_ff.pair;

endmodule : arc_result_format

// file: core/arc_conv_ctrl.sv
// converter control: wishbone registers, successive approximation, sleep start
`timescale 1ns/1ps
module arc_conv_ctrl (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic comparator_i,
    input wire logic [1:0] sleep_mode_i,
    input wire logic cpu_halted_i,
    output logic [arc_pkg::RES_W-1:0] dac_code_o,
    output logic [1:0] reference_select_o,
    output logic diff_select_o,
    output logic sample_hold_o,
    output logic converter_power_o,
    output logic conv_irq_o,
    output logic cpu_wake_o
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic converter_enable;
        logic start_conversion_bit;
        logic irq_enable;
        logic conversion_done_flag;
        logic [1:0] ref_req;
        logic left_adjust_result;
        logic diff_req;
        logic [1:0] ref_act;
        logic diff_act;
        arc_pkg::arc_conv_st_t cv;
        logic [3:0] bit_idx;
        logic [arc_pkg::SETTLE_W-1:0] settle;
        logic [arc_pkg::RES_W-1:0] trial;
        logic [arc_pkg::RES_W-1:0] result;
        logic first_pending;
        logic halted_d;
        logic sleep_conv;
        logic wake;
        logic irq;
        logic hold;
    } arc_ctrl_st_t;

    arc_ctrl_st_t st_ff;
    arc_ctrl_st_t nxt_st;

    arc_pkg::arc_wb_req_t req;
    arc_pkg::arc_res_pair_t pair;
    logic cmp_level;
    logic bus_hit;
    logic wr_ctrl;
    logic wr_sel;
    logic done_evt;
    logic quiet_sleep;
    logic halt_rise;
    logic [arc_pkg::RES_W-1:0] onehot;
    logic [arc_pkg::RES_W-1:0] decided;
    logic [arc_pkg::RES_W-1:0] formatted;

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;

    // ****************************************************
    // submodules
    // ****************************************************
    arc_pin_sync u_cmp_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i(comparator_i),
        .level_o(cmp_level)
    );

    arc_result_format u_format (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .result_i(st_ff.result),
        .left_adjust_result_i(st_ff.left_adjust_result),
        .pair_o(pair)
    );

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        nxt_st = st_ff;
        onehot = arc_pkg::RES_ONE << st_ff.bit_idx;
        decided = st_ff.trial;
        formatted = st_ff.trial;
        done_evt = 1'b0;
        bus_hit = req.cyc && req.stb && !st_ff.ack;
        wr_ctrl = bus_hit && req.we && req.sel[0] && (req.adr == arc_pkg::ADDR_CTRL);
        wr_sel = bus_hit && req.we && req.sel[0] && (req.adr == arc_pkg::ADDR_SEL);
        quiet_sleep = (sleep_mode_i == arc_pkg::ARC_SLP_IDLE)
            || (sleep_mode_i == arc_pkg::ARC_SLP_NOISE);
        halt_rise = cpu_halted_i && !st_ff.halted_d;
        nxt_st.halted_d = cpu_halted_i;
        nxt_st.wake = 1'b0;

        // ------------------------------------------------
        // bus slave: one-cycle ack, zero for unmapped
        // ------------------------------------------------
        nxt_st.ack = bus_hit;
        nxt_st.rdata = '0;
        if (bus_hit && !req.we)
        begin
            case (req.adr)
                arc_pkg::ADDR_CTRL:
                begin
                    nxt_st.rdata[arc_pkg::CTRL_EN_BIT] = st_ff.converter_enable;
                    nxt_st.rdata[arc_pkg::CTRL_START_BIT] = st_ff.start_conversion_bit;
                    nxt_st.rdata[arc_pkg::CTRL_IE_BIT] = st_ff.irq_enable;
                    nxt_st.rdata[arc_pkg::CTRL_DONE_BIT] = st_ff.conversion_done_flag;
                    nxt_st.rdata[arc_pkg::CTRL_BUSY_BIT] = (st_ff.cv != arc_pkg::ARC_CV_IDLE);
                end
                arc_pkg::ADDR_SEL:
                begin
                    nxt_st.rdata[arc_pkg::SEL_REF_LSB +: 2] = st_ff.ref_req;
                    nxt_st.rdata[arc_pkg::SEL_LADJ_BIT] = st_ff.left_adjust_result;
                    nxt_st.rdata[arc_pkg::SEL_DIFF_BIT] = st_ff.diff_req;
                end
                arc_pkg::ADDR_RES_LO:
                begin
                    nxt_st.rdata[7:0] = pair.lo;
                end
                arc_pkg::ADDR_RES_HI:
                begin
                    nxt_st.rdata[7:0] = pair.hi;
                end
                default:
                begin
                    nxt_st.rdata = '0;
                end
            endcase
        end

        // ------------------------------------------------
        // register writes
        // ------------------------------------------------
        if (wr_sel)
        begin
            nxt_st.ref_req = req.dat[arc_pkg::SEL_REF_LSB +: 2];
            nxt_st.left_adjust_result = req.dat[arc_pkg::SEL_LADJ_BIT];
            nxt_st.diff_req = req.dat[arc_pkg::SEL_DIFF_BIT];
        end
        if (wr_ctrl)
        begin
            nxt_st.converter_enable = req.dat[arc_pkg::CTRL_EN_BIT];
            nxt_st.irq_enable = req.dat[arc_pkg::CTRL_IE_BIT];
            if (req.dat[arc_pkg::CTRL_START_BIT] && req.dat[arc_pkg::CTRL_EN_BIT])
            begin
                nxt_st.start_conversion_bit = 1'b1;
            end
            if (req.dat[arc_pkg::CTRL_DONE_BIT])
            begin
                nxt_st.conversion_done_flag = 1'b0;
            end
            if (req.dat[arc_pkg::CTRL_EN_BIT] && !st_ff.converter_enable)
            begin
                nxt_st.first_pending = 1'b1;
            end
        end

        // ------------------------------------------------
        // automatic start when the cpu halts in quiet sleep
        // ------------------------------------------------
        // only the halt edge arms it, so a woken cpu is not re-slept
        if (halt_rise && quiet_sleep && st_ff.converter_enable
            && (st_ff.cv == arc_pkg::ARC_CV_IDLE) && !st_ff.start_conversion_bit)
        begin
            nxt_st.start_conversion_bit = 1'b1;
            nxt_st.sleep_conv = 1'b1;
        end

        // reference and input type follow the request while idle
        if (st_ff.cv == arc_pkg::ARC_CV_IDLE)
        begin
            nxt_st.ref_act = st_ff.ref_req;
            nxt_st.diff_act = st_ff.diff_req;
        end

        // ------------------------------------------------
        // successive approximation
        // ------------------------------------------------
        case (st_ff.cv)
            arc_pkg::ARC_CV_IDLE:
            begin
                nxt_st.hold = 1'b0;
                if (st_ff.start_conversion_bit && st_ff.converter_enable)
                begin
                    nxt_st.cv = arc_pkg::ARC_CV_SETTLE;
                    nxt_st.bit_idx = arc_pkg::RES_TOP_IDX;
                    nxt_st.trial = arc_pkg::RES_ONE << arc_pkg::RES_TOP_IDX;
                    nxt_st.hold = 1'b1;
                    nxt_st.ref_act = st_ff.ref_req;
                    nxt_st.diff_act = st_ff.diff_req;
                    nxt_st.first_pending = 1'b0;
                    if (st_ff.first_pending)
                    begin
                        nxt_st.settle = arc_pkg::INIT_SETTLE;
                    end
                    else
                    begin
                        nxt_st.settle = arc_pkg::BIT_SETTLE;
                    end
                end
            end
            arc_pkg::ARC_CV_SETTLE:
            begin
                if (!st_ff.converter_enable)
                begin
                    nxt_st.cv = arc_pkg::ARC_CV_IDLE;
                    nxt_st.start_conversion_bit = 1'b0;
                    nxt_st.sleep_conv = 1'b0;
                    nxt_st.hold = 1'b0;
                end
                // count down to zero: the filtered comparator trails the trial by four edges
                else if (st_ff.settle != '0)
                begin
                    nxt_st.settle = st_ff.settle - arc_pkg::SETTLE_ONE;
                end
                else
                begin
                    // a high comparator keeps the trial bit, so overrange
                    // inputs settle on the top code instead of wrapping
                    if (!cmp_level)
                    begin
                        decided = st_ff.trial & ~onehot;
                    end
                    nxt_st.trial = decided;
                    if (st_ff.bit_idx == 4'h0)
                    begin
                        nxt_st.cv = arc_pkg::ARC_CV_DONE;
                    end
                    else
                    begin
                        nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
                        nxt_st.trial = decided | (onehot >> 1);
                        nxt_st.settle = arc_pkg::BIT_SETTLE;
                    end
                end
            end
            arc_pkg::ARC_CV_DONE:
            begin
                // differential search runs in offset binary; flip the msb
                if (st_ff.diff_act)
                begin
                    formatted[arc_pkg::RES_MSB] = ~st_ff.trial[arc_pkg::RES_MSB];
                end
                nxt_st.result = formatted;
                nxt_st.conversion_done_flag = 1'b1;
                nxt_st.start_conversion_bit = 1'b0;
                nxt_st.cv = arc_pkg::ARC_CV_IDLE;
                nxt_st.hold = 1'b0;
                nxt_st.ref_act = st_ff.ref_req;
                nxt_st.diff_act = st_ff.diff_req;
                done_evt = 1'b1;
                nxt_st.sleep_conv = 1'b0;
                if (st_ff.sleep_conv && cpu_halted_i)
                begin
                    nxt_st.wake = 1'b1;
                end
            end
            default:
            begin
                nxt_st.cv = arc_pkg::ARC_CV_IDLE;
            end
        endcase

        // set wins over a clear in the same cycle
        if (done_evt)
        begin
            nxt_st.conversion_done_flag = 1'b1;
        end

        // request stands while flag and enable are high, woken or not
        nxt_st.irq = nxt_st.conversion_done_flag && nxt_st.irq_enable;
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
            st_ff.cv <= arc_pkg::ARC_CV_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign wb_dat_o = st_ff.rdata;
    assign wb_ack_o = st_ff.ack;
    assign dac_code_o = st_ff.trial;
    assign reference_select_o = st_ff.ref_act;
    assign diff_select_o = st_ff.diff_act;
    assign sample_hold_o = st_ff.hold;
    // power follows the enable only, whatever the sleep mode
    assign converter_power_o = st_ff.converter_enable;
    assign conv_irq_o = st_ff.irq;
    assign cpu_wake_o = st_ff.wake;

endmodule : arc_conv_ctrl

// file: bench/arc_conv_sva.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module arc_conv_sva (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] sleep_mode_i,
    input wire logic cpu_halted_i,
    input wire logic [arc_pkg::RES_W-1:0] dac_code_o,
    input wire logic [1:0] reference_select_o,
    input wire logic sample_hold_o,
    input wire logic converter_power_o,
    input wire logic conv_irq_o,
    input wire logic cpu_wake_o
);
    // ****************************************************
    // sequences and assertions
    // ****************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    // cpu halts in a quiet sleep with the converter ready
    sequence quiet_halt_s;
        $rose(cpu_halted_i) && (sleep_mode_i inside {2'h1, 2'h2}) && converter_power_o
            && !sample_hold_o && !$past(sample_hold_o) && !wb_cyc_i;
    endsequence

    sequence conv_begun_s;
        ##[1:2] sample_hold_o;
    endsequence

    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    sleep_start_a: assert property (quiet_halt_s |-> conv_begun_s)
        else $error("no conversion after cpu halt in quiet sleep");
    dac_first_a: assert property ($rose(sample_hold_o) |-> dac_code_o == 10'h200)
        else $error("first trial code is not midscale");
    ref_locked_a: assert property (sample_hold_o && $past(sample_hold_o)
        |-> $stable(reference_select_o))
        else $error("reference changed during conversion");
    power_kept_a: assert property (converter_power_o && sleep_mode_i == 2'h3 && !wb_cyc_i
        |=> converter_power_o)
        else $error("converter lost power in other sleep mode");
    wake_pulse_a: assert property (cpu_wake_o |=> !cpu_wake_o [*3])
        else $error("wake not a single pulse");
    irq_held_a: assert property (conv_irq_o && !wb_cyc_i |=> conv_irq_o)
        else $error("completion request dropped without software");
endmodule : arc_conv_sva

bind arc_conv_ctrl arc_conv_sva i_sva (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sleep_mode_i(sleep_mode_i), .cpu_halted_i(cpu_halted_i),
    .dac_code_o(dac_code_o), .reference_select_o(reference_select_o),
    .sample_hold_o(sample_hold_o), .converter_power_o(converter_power_o),
    .conv_irq_o(conv_irq_o), .cpu_wake_o(cpu_wake_o)
);

// file: bench/arc_analog_model.sv
// analog input and comparator stand-in
`timescale 1ns/1ps
module arc_analog_model (
    input wire logic [9:0] dac_code_i,
    input wire logic [10:0] level_i,
    output logic comparator_o
);
    // level in codes, offset binary when differential; overrange keeps all bits set
    // ideal: no settling error after a reference change, no residual offset
    assign comparator_o = ({1'b0, dac_code_i} <= level_i);
endmodule : arc_analog_model

// file: bench/adc_result_and_sleep_convert_test.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module adc_result_and_sleep_convert_test;
    typedef struct packed {
        logic [10:0] lvl;
        logic diff;
        logic ladj;
        logic [1:0] refs;
        logic [7:0] lo;
        logic [7:0] hi;
    } arc_tb_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic [1:0] mode = 2'h0;
    logic halted = 1'b0;
    logic [10:0] lvl = 11'h000;
    logic cmp, ack, dsel, hold, pwr, irq, wake;
    logic [9:0] dac;
    logic [1:0] refsel;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    // pin reference rows assume no source on the external pin
    arc_tb_row_t rows [7] = '{
        '{11'h000, 1'b0, 1'b0, 2'h0, 8'h00, 8'h00},
        '{11'h3ff, 1'b0, 1'b0, 2'h1, 8'hff, 8'h03},
        '{11'h5a5, 1'b0, 1'b1, 2'h2, 8'hc0, 8'hff},
        '{11'h070, 1'b1, 1'b1, 2'h3, 8'h00, 8'h9c},
        '{11'h3ff, 1'b1, 1'b0, 2'h1, 8'hff, 8'h01},
        '{11'h155, 1'b0, 1'b1, 2'h0, 8'h40, 8'h55},
        '{11'h000, 1'b1, 1'b0, 2'h0, 8'h00, 8'h02}
    };

    arc_conv_ctrl i_dut (
        .core_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .comparator_i(cmp), .sleep_mode_i(mode), .cpu_halted_i(halted), .dac_code_o(dac),
        .reference_select_o(refsel), .diff_select_o(dsel), .sample_hold_o(hold),
        .converter_power_o(pwr), .conv_irq_o(irq), .cpu_wake_o(wake)
    );
    arc_analog_model i_ana (.dac_code_i(dac), .level_i(lvl), .comparator_o(cmp));

    // ****************************************************
    // clock, timeout, helpers
    // ****************************************************
    initial
    begin
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one classic cycle; values seen right after an edge are those sampled at it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic poll_done();
        do
        begin
            xfer(1'b0, arc_pkg::ADDR_CTRL, 32'h0);
        end
        while (rdat[arc_pkg::CTRL_DONE_BIT] !== 1'b1);
    endtask : poll_done

    task automatic wait_sig(input logic want_irq);
        n = 0;
        while ((want_irq ? irq : wake) !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_sig

    task automatic read_pair(input logic [7:0] lo, input logic [7:0] hi);
        xfer(1'b0, arc_pkg::ADDR_RES_LO, 32'h0);
        chk("result_low_byte", rdat, {24'h0, lo});
        xfer(1'b0, arc_pkg::ADDR_RES_HI, 32'h0);
        chk("result_high_byte", rdat, {24'h0, hi});
    endtask : read_pair

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ****************************************************
    // tests
    // ****************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        chk("reset outputs", 32'({dac, refsel, dsel, hold, pwr, irq, wake, ack}), 32'h0);
        srst <= 1'b0;
        xfer(1'b0, arc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", rdat, 32'h0);
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped read", rdat, 32'h0);
        $display("reset test done");
        foreach (rows[i])
        begin
            lvl <= rows[i].lvl;
            xfer(1'b1, arc_pkg::ADDR_SEL, {28'h0, rows[i].diff, rows[i].ladj, rows[i].refs});
            xfer(1'b1, arc_pkg::ADDR_CTRL, 32'h7);
            poll_done();
            chk("start cleared", 32'(rdat[arc_pkg::CTRL_START_BIT]), 32'h0);
            chk("reference", 32'(refsel), 32'(rows[i].refs));
            chk("diff", 32'(dsel), 32'(rows[i].diff));
            chk("irq", 32'(irq), 32'h1);
            read_pair(rows[i].lo, rows[i].hi);
            xfer(1'b1, arc_pkg::ADDR_CTRL, 32'hd);
            $display("row %0d done", i);
        end
        // left adjust flip on the most negative differential result
        xfer(1'b1, arc_pkg::ADDR_SEL, 32'he);
        read_pair(8'h00, 8'h80);
        $display("adjust test done");
        // noise-reduction sleep start, completion wakes
        lvl <= 11'h2aa;
        xfer(1'b1, arc_pkg::ADDR_SEL, 32'h1);
        xfer(1'b1, arc_pkg::ADDR_CTRL, 32'h5);
        mode <= arc_pkg::ARC_SLP_NOISE;
        halted <= 1'b1;
        wait_sig(1'b0);
        chk("wake", 32'(wake), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        @(posedge clk);
        halted <= 1'b0;
        mode <= arc_pkg::ARC_SLP_ACTIVE;
        repeat (40) @(posedge clk);
        chk("stays idle", 32'(hold), 32'h0);
        read_pair(8'haa, 8'h02);
        xfer(1'b1, arc_pkg::ADDR_CTRL, 32'hd);
        $display("noise sleep test done");
        // idle sleep, another wake source ends the halt early
        mode <= arc_pkg::ARC_SLP_IDLE;
        halted <= 1'b1;
        repeat (8) @(posedge clk);
        halted <= 1'b0;
        mode <= arc_pkg::ARC_SLP_ACTIVE;
        wait_sig(1'b1);
        chk("late irq", 32'(irq), 32'h1);
        chk("no wake", 32'(wake), 32'h0);
        xfer(1'b1, arc_pkg::ADDR_CTRL, 32'hd);
        $display("idle sleep test done");
        // other sleep mode: no start, power kept
        mode <= arc_pkg::ARC_SLP_OTHER;
        halted <= 1'b1;
        repeat (30) @(posedge clk);
        chk("power kept", 32'(pwr), 32'h1);
        chk("no start", 32'(hold), 32'h0);
        halted <= 1'b0;
        mode <= arc_pkg::ARC_SLP_ACTIVE;
        $display("other sleep test done");
        // off and on after waking, then a differential extended conversion
        xfer(1'b1, arc_pkg::ADDR_CTRL, 32'h0);
        xfer(1'b1, arc_pkg::ADDR_SEL, 32'h9);
        xfer(1'b1, arc_pkg::ADDR_CTRL, 32'h7);
        poll_done();
        read_pair(8'haa, 8'h00);
        $display("re-enable test done");
        summarize();
    end
endmodule : adc_result_and_sleep_convert_test
